// File: hdl/tudc_pkg.sv
// Purpose: Shared constants and types for the trigger debug and count block
// Assumes: 8-bit register port, 25 MHz bus clock
// Notes:   Register offsets are local choices (see hand-over)
package tudc_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [3:0] ADDR_COUNT    = 4'h0;
  localparam logic [3:0] ADDR_VALUE_HI = 4'h1;
  localparam logic [3:0] ADDR_VALUE_LO = 4'h2;
  localparam logic [3:0] ADDR_DEBUG    = 4'h3;
  localparam logic [3:0] ADDR_CONTROL  = 4'h4;
  localparam logic [3:0] ADDR_STATUS   = 4'h5;
  localparam logic [3:0] ADDR_MASK     = 4'h6;

  // ****************************************************
  // Debug register fields
  // ****************************************************
  localparam int BIT_RELOAD_PE   = 6;
  localparam int BIT_TRIG1_PE    = 5;
  localparam int BIT_TRIG0_PE    = 4;
  localparam int BIT_FORCE_RLD   = 2;
  localparam int BIT_FORCE_TRIG1 = 1;
  localparam int BIT_FORCE_TRIG0 = 0;
  localparam logic [7:0] DEBUG_PE_MASK = 8'h70;

  // ****************************************************
  // Control register fields
  // ****************************************************
  localparam int BIT_GEN0_EN = 0;
  localparam int BIT_GEN1_EN = 1;

  // ****************************************************
  // Status register fields (sticky events)
  // ****************************************************
  localparam int BIT_EV_RELOAD = 0;
  localparam int BIT_EV_TRIG0  = 1;
  localparam int BIT_EV_TRIG1  = 2;
  localparam int BIT_EV_WRAP   = 3;
  localparam int EV_WIDTH      = 4;

  // ****************************************************
  // Counts and resets
  // ****************************************************
  localparam int            TRIG_WRAP      = 32;
  localparam logic [7:0]    RESET_BYTE     = 8'h00;
  localparam logic [15:0]   RESET_VALUE    = 16'h0000;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tudc_bus_t;

  typedef struct packed {
    logic stop;
    logic freeze;
    logic special;
  } tudc_mode_t;

endpackage

// File: hdl/tudc_count.sv
// Purpose: Trigger counter of the second generator, wraps to zero
// Assumes: Inputs are synchronous to the clock
// Notes:   Clear has priority over increment in the same cycle
`timescale 1ns/1ps
`default_nettype none
module tudc_count
#(
  parameter int WRAP = tudc_pkg::TRIG_WRAP
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Events
  input  wire logic       clear,
  input  wire logic       incr,
  // State
  output logic [7:0]      count,
  output logic            wrap
);

  // The count is 8 bits wide, so the wrap point must fit below 256
  if (WRAP < 2 || WRAP > 255)
  begin : g_wrap_check
    $error("tudc_count: WRAP out of range");
  end

  logic [7:0] next_count;

  always_comb
  begin
    next_count = count;
    wrap       = 1'b0;
    if (clear)
      next_count = tudc_pkg::RESET_BYTE;
    else if (incr)
    begin
      if (count == 8'(WRAP - 1))
      begin
        next_count = tudc_pkg::RESET_BYTE;
        wrap       = 1'b1;
      end
      else
        next_count = count + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= tudc_pkg::RESET_BYTE;
    else
      count <= next_count;
  end

endmodule
`default_nettype wire

// File: hdl/tudc_top.sv
// Purpose: Debug and status part of a two-generator trigger unit
// Assumes: 8-bit register port, reads answered one cycle later
// Notes:   Generator list engine is outside; its triggers arrive as pulses
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tudc_top
(
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  // Register port
  input  wire logic [3:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [7:0]       RDATA,
  // Chip mode
  input  wire logic        SPECIAL_MODE,
  input  wire logic        STOP_MODE,
  input  wire logic        FREEZE_MODE,
  // Trigger engine side
  input  wire logic        LIST_TRIG0,
  input  wire logic        LIST_TRIG1,
  input  wire logic        LIST_RELOAD,
  input  wire logic [15:0] TRIG_VALUE,
  // Outputs
  output logic             RELOAD_PULSE,
  output logic             TRIG0_PULSE,
  output logic             TRIG1_PULSE,
  output logic             RELOAD_PIN,
  output logic             FIRST_TRIGGER_PIN,
  output logic             SECOND_TRIGGER_PIN,
  output logic             RELOAD_INTERRUPT_FLAG,
  output logic             UNIT_ACTIVE,
  output logic             IRQ
);

  // ****************************************************
  // Bus decode
  // ****************************************************
  tudc_pkg::tudc_bus_t  bus;
  tudc_pkg::tudc_mode_t mode;

  assign bus  = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign mode = '{stop: STOP_MODE, freeze: FREEZE_MODE,
                  special: SPECIAL_MODE};

  function automatic logic hit(input tudc_pkg::tudc_bus_t b,
                               input logic [3:0] a);
    hit = b.wr && (b.addr == a);
  endfunction

  // ****************************************************
  // Software state
  // ****************************************************
  logic [2:0]  pin_en;
  logic [1:0]  gen_en;
  logic [3:0]  irq_mask;
  logic        force_rld;
  logic        force_t0;
  logic        force_t1;
  logic [2:0]  next_pin_en;
  logic [1:0]  next_gen_en;
  logic [3:0]  next_irq_mask;
  logic        next_force_rld;
  logic        next_force_t0;
  logic        next_force_t1;
  logic        dbg_wr;
  logic        any_en;
  logic        halted;

  assign any_en  = |gen_en;
  assign halted  = mode.stop || mode.freeze;
  assign dbg_wr  = hit(bus, tudc_pkg::ADDR_DEBUG) && mode.special;

  always_comb
  begin
    next_pin_en    = pin_en;
    next_gen_en    = gen_en;
    next_irq_mask  = irq_mask;
    next_force_rld = 1'b0;
    next_force_t0  = 1'b0;
    next_force_t1  = 1'b0;
    if (dbg_wr)
    begin
      next_pin_en = {bus.wdata[tudc_pkg::BIT_RELOAD_PE],
                     bus.wdata[tudc_pkg::BIT_TRIG1_PE],
                     bus.wdata[tudc_pkg::BIT_TRIG0_PE]};
      // Force bits are strobes: zeros written do nothing
      next_force_rld = bus.wdata[tudc_pkg::BIT_FORCE_RLD] && any_en
                       && !halted;
      next_force_t1  = bus.wdata[tudc_pkg::BIT_FORCE_TRIG1]
                       && gen_en[tudc_pkg::BIT_GEN1_EN]
                       && !halted;
      next_force_t0  = bus.wdata[tudc_pkg::BIT_FORCE_TRIG0]
                       && gen_en[tudc_pkg::BIT_GEN0_EN]
                       && !halted;
    end
    if (hit(bus, tudc_pkg::ADDR_CONTROL))
      next_gen_en = bus.wdata[1:0];
    if (hit(bus, tudc_pkg::ADDR_MASK))
      next_irq_mask = bus.wdata[3:0];
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      pin_en    <= 3'h0;
      gen_en    <= 2'h0;
      irq_mask  <= 4'h0;
      force_rld <= 1'b0;
      force_t0  <= 1'b0;
      force_t1  <= 1'b0;
    end
    else
    begin
      pin_en    <= next_pin_en;
      gen_en    <= next_gen_en;
      irq_mask  <= next_irq_mask;
      force_rld <= next_force_rld;
      force_t0  <= next_force_t0;
      force_t1  <= next_force_t1;
    end
  end

  // ****************************************************
  // Event merge
  // ****************************************************
  logic list_rld;
  logic ev_rld;
  logic ev_t0;
  logic ev_t1;

  // List events only count while the unit runs
  assign list_rld = LIST_RELOAD && any_en;
  assign ev_rld   = list_rld || force_rld;
  assign ev_t0    = (LIST_TRIG0 && gen_en[tudc_pkg::BIT_GEN0_EN])
                    || force_t0;
  assign ev_t1    = (LIST_TRIG1 && gen_en[tudc_pkg::BIT_GEN1_EN])
                    || force_t1;

  logic [7:0] count;
  logic       wrap;

  tudc_count
  #(
    .WRAP (tudc_pkg::TRIG_WRAP)
  )
  u_count
  (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .clear (ev_rld),
    .incr  (ev_t1),
    .count (count),
    .wrap  (wrap)
  );

  // ****************************************************
  // Outputs, flags and value capture
  // ****************************************************
  logic [15:0] value;
  logic        rld_flag;
  logic [3:0]  status;
  logic [7:0]  rd_mux;
  logic [15:0] next_value;
  logic        next_rld_flag;
  logic [3:0]  next_status;
  logic [3:0]  ev_vec;
  logic        rd_status;
  logic        next_rld_pulse;
  logic        next_t0_pulse;
  logic        next_t1_pulse;

  assign rd_status = bus.rd && (bus.addr == tudc_pkg::ADDR_STATUS);
  assign ev_vec    = {wrap, ev_t1, ev_t0, ev_rld};

  always_comb
  begin
    next_value     = ev_t1 ? TRIG_VALUE : value;
    // Only list reloads raise the flag, never a forced one
    next_rld_flag  = rld_flag || list_rld;
    if (hit(bus, tudc_pkg::ADDR_STATUS) && !list_rld)
      next_rld_flag = 1'b0;
    next_status    = (rd_status ? 4'h0 : status) | ev_vec;
    next_rld_pulse = ev_rld;
    next_t0_pulse  = ev_t0;
    next_t1_pulse  = ev_t1;
    case (bus.addr)
      tudc_pkg::ADDR_COUNT:    rd_mux = count;
      tudc_pkg::ADDR_VALUE_HI: rd_mux = value[15:8];
      tudc_pkg::ADDR_VALUE_LO: rd_mux = value[7:0];
      tudc_pkg::ADDR_DEBUG:
        rd_mux = {1'b0, pin_en, 4'h0};
      tudc_pkg::ADDR_CONTROL:  rd_mux = {6'h00, gen_en};
      tudc_pkg::ADDR_STATUS:   rd_mux = {3'h0, rld_flag, status};
      tudc_pkg::ADDR_MASK:     rd_mux = {4'h0, irq_mask};
      default:                 rd_mux = tudc_pkg::RESET_BYTE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      value        <= 16'h0000;
      rld_flag     <= 1'b0;
      status       <= 4'h0;
      RDATA        <= 8'h00;
      RELOAD_PULSE <= 1'b0;
      TRIG0_PULSE  <= 1'b0;
      TRIG1_PULSE  <= 1'b0;
    end
    else
    begin
      value        <= next_value;
      rld_flag     <= next_rld_flag;
      status       <= next_status;
      RDATA        <= bus.rd ? rd_mux : tudc_pkg::RESET_BYTE;
      RELOAD_PULSE <= next_rld_pulse;
      TRIG0_PULSE  <= next_t0_pulse;
      TRIG1_PULSE  <= next_t1_pulse;
    end
  end

  assign RELOAD_PIN         = RELOAD_PULSE && pin_en[2];
  assign SECOND_TRIGGER_PIN = TRIG1_PULSE && pin_en[1];
  assign FIRST_TRIGGER_PIN  = TRIG0_PULSE && pin_en[0];
  assign RELOAD_INTERRUPT_FLAG = rld_flag;
  assign UNIT_ACTIVE        = any_en;
  assign IRQ                = |(status & irq_mask);

endmodule
`default_nettype wire

// File: test/tudc_asserts.sv
// Purpose: Port checks for the trigger debug and count block
// Assumes: One clock, async active-low reset
// Notes:   Debug write decode repeated here to stay port-only
`timescale 1ns/1ps
`default_nettype none
module tudc_asserts
(
  // Clock, reset, register port, modes
  input wire logic       SYS_CLK,
  input wire logic       RESETN,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       SPECIAL_MODE,
  input wire logic       STOP_MODE,
  input wire logic       FREEZE_MODE,
  // Engine side and outputs
  input wire logic       LIST_TRIG0,
  input wire logic       LIST_TRIG1,
  input wire logic       LIST_RELOAD,
  input wire logic       RELOAD_PULSE,
  input wire logic       TRIG0_PULSE,
  input wire logic       TRIG1_PULSE,
  input wire logic       RELOAD_PIN,
  input wire logic       FIRST_TRIGGER_PIN,
  input wire logic       SECOND_TRIGGER_PIN,
  input wire logic       RELOAD_INTERRUPT_FLAG,
  input wire logic       UNIT_ACTIVE
);
  // List pulses would mask a missing block, so they are excluded
  wire logic       dbg_wr = WR && ADDR == tudc_pkg::ADDR_DEBUG;
  wire logic       quiet  = !LIST_RELOAD && !LIST_TRIG0 && !LIST_TRIG1;
  wire logic [2:0] pls    = {RELOAD_PULSE, TRIG1_PULSE, TRIG0_PULSE};
  wire logic [2:0] pin    = {RELOAD_PIN, SECOND_TRIGGER_PIN,
                             FIRST_TRIGGER_PIN};

  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);

  a_reload_single:
    assert property (RELOAD_PULSE && quiet && !$past(dbg_wr)
      |=> !RELOAD_PULSE)
    else $error("reload pulse wider than one cycle");
  a_force_reload:
    assert property (dbg_wr && WDATA[2] && SPECIAL_MODE && !STOP_MODE
      && !FREEZE_MODE && UNIT_ACTIVE |=> ##1 RELOAD_PULSE)
    else $error("forced reload missing");
  a_halt_blocks:
    assert property (dbg_wr && (STOP_MODE || FREEZE_MODE) ##1 quiet
      |=> pls == 3'h0)
    else $error("force acted in stop or freeze");
  a_special_only:
    assert property (dbg_wr && !SPECIAL_MODE ##1 quiet |=> pls == 3'h0)
    else $error("debug write taken outside special mode");
  a_pin_gate:
    assert property ((pin & ~pls) == 3'h0)
    else $error("pin high without its pulse");
  a_flag_cause:
    assert property ($rose(RELOAD_INTERRUPT_FLAG) |-> $past(LIST_RELOAD))
    else $error("reload flag set without list reload");
  a_force_zero:
    assert property (RD && ADDR == tudc_pkg::ADDR_DEBUG
      |=> RDATA[2:0] == 3'h0)
    else $error("force bits read back nonzero");
  a_idle_quiet:
    assert property (!UNIT_ACTIVE && !$past(UNIT_ACTIVE) |=> pls == 3'h0)
    else $error("pulse while both generators off");
endmodule

bind tudc_top tudc_asserts u_asserts (.SYS_CLK, .RESETN, .ADDR, .WDATA,
  .WR, .RD, .RDATA, .SPECIAL_MODE, .STOP_MODE, .FREEZE_MODE, .LIST_TRIG0,
  .LIST_TRIG1, .LIST_RELOAD, .RELOAD_PULSE, .TRIG0_PULSE, .TRIG1_PULSE,
  .RELOAD_PIN, .FIRST_TRIGGER_PIN, .SECOND_TRIGGER_PIN,
  .RELOAD_INTERRUPT_FLAG, .UNIT_ACTIVE);
`default_nettype wire

// File: test/tudc_far.sv
// Purpose: Behavioural list engine feeding the block
// Assumes: Pulses launched just after a rising edge
// Notes:   Value steps both bytes so a swapped pair shows
`timescale 1ns/1ps
`default_nettype none
module tudc_far
#(
  parameter logic [15:0] FIRST_VALUE = 16'h12F0
)
(
  // Clock
  input  wire logic        clk,
  // Engine outputs: {reload, trig1, trig0}
  output logic [2:0]       list_ev,
  output logic [15:0]      value
);
  initial
  begin
    list_ev = 3'h0;
    value = FIRST_VALUE;
  end

  task automatic fire(input int k);
    @(posedge clk);
    list_ev[k] <= 1'b1;
    if (k == 1)
      value <= value + 16'h0101;
    @(posedge clk);
    list_ev[k] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: test/tudc_bench.sv
// Purpose: Register-level tests of the trigger debug and count block
// Assumes: Register map as the package lays it out
// Notes:   Count wrap and clear expectations follow the hand-over
`timescale 1ns/1ps
`default_nettype none
module tudc_bench;
  tudc_pkg::tudc_bus_t  bus;
  tudc_pkg::tudc_mode_t mode;
  logic                 sys_clk;
  logic                 resetn;
  logic [7:0]           rdata;
  wire logic [2:0]      ev;
  wire logic [15:0]     value;
  logic [2:0]           pls;
  logic [2:0]           pin;
  logic                 flag;
  logic                 active;
  logic                 irq;
  int                   num_errors;
  int                   checks_done;
  // Mode bits: [2] stop, [1] freeze, [0] special
  wire logic [3:0]      p_addr  = bus.addr;
  wire logic [7:0]      p_wdata = bus.wdata;
  wire logic            p_wr    = bus.wr;
  wire logic            p_rd    = bus.rd;
  wire logic [2:0]      p_mode  = mode;

  tudc_top DUT (.SYS_CLK(sys_clk), .RESETN(resetn), .ADDR(p_addr),
    .WDATA(p_wdata), .WR(p_wr), .RD(p_rd), .RDATA(rdata),
    .SPECIAL_MODE(p_mode[0]), .STOP_MODE(p_mode[2]),
    .FREEZE_MODE(p_mode[1]), .LIST_TRIG0(ev[0]), .LIST_TRIG1(ev[1]),
    .LIST_RELOAD(ev[2]), .TRIG_VALUE(value), .RELOAD_PULSE(pls[2]),
    .TRIG1_PULSE(pls[1]), .TRIG0_PULSE(pls[0]), .RELOAD_PIN(pin[2]),
    .SECOND_TRIGGER_PIN(pin[1]), .FIRST_TRIGGER_PIN(pin[0]),
    .RELOAD_INTERRUPT_FLAG(flag), .UNIT_ACTIVE(active), .IRQ(irq));
  tudc_far far (.clk(sys_clk), .list_ev(ev), .value(value));

  always #20 sys_clk = ~sys_clk;

  // ********************
  // Access tasks
  // ********************
  task automatic chk(input string n, input logic [15:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rc(input string n, input logic [3:0] a,
                    input logic [7:0] e);
    @(posedge sys_clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    @(negedge sys_clk);
    chk(n, rdata, e);
  endtask

  task automatic dbg(input logic [7:0] v, input logic [2:0] p, q);
    wr(4'h3, v);
    // Force is registered at the write edge, the pulse one edge later
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("pulses", pls, p);
    chk("pins", pin, q);
  endtask

  task automatic md(input logic [2:0] m);
    @(posedge sys_clk);
    mode <= m;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ********************
  // Tests
  // ********************
  initial
  begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    bus = '0;
    mode = 3'b001;
    num_errors = 0;
    checks_done = 0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 3; a++)
    begin
      wr(4'(a), 8'hFF);
      rc("ro byte", 4'(a), 8'h00);
    end
    rc("unmapped", 4'hF, 8'h00);
    $display("done: read-only");
    wr(4'h4, 8'h03);
    repeat (5) far.fire(1);
    rc("count", 4'h0, 8'h05);
    rc("value hi", 4'h1, value[15:8]);
    rc("value lo", 4'h2, value[7:0]);
    repeat (27) far.fire(1);
    rc("count wrap", 4'h0, 8'h00);
    rc("status", 4'h5, 8'h0C);
    chk("irq masked", irq, 1'b0);
    $display("done: count");
    repeat (3) far.fire(1);
    dbg(8'h04, 3'b100, 3'b000);
    @(negedge sys_clk);
    chk("reload end", pls[2], 1'b0);
    rc("count clear", 4'h0, 8'h00);
    rc("forced flag", 4'h5, 8'h05);
    chk("int flag", flag, 1'b0);
    far.fire(2);
    rc("list reload", 4'h5, 8'h11);
    chk("int flag", flag, 1'b1);
    rc("flag held", 4'h5, 8'h10);
    wr(4'h5, 8'h00);
    rc("flag clear", 4'h5, 8'h00);
    $display("done: reload");
    dbg(8'h01, 3'b001, 3'b000);
    dbg(8'h02, 3'b010, 3'b000);
    rc("count", 4'h0, 8'h01);
    dbg(8'h70, 3'b000, 3'b000);
    rc("debug", 4'h3, 8'h70);
    dbg(8'h77, 3'b111, 3'b111);
    rc("debug", 4'h3, 8'h70);
    md(3'b101);
    dbg(8'h77, 3'b000, 3'b000);
    md(3'b011);
    dbg(8'h77, 3'b000, 3'b000);
    md(3'b000);
    dbg(8'h07, 3'b000, 3'b000);
    wr(4'h3, 8'h00);
    rc("debug locked", 4'h3, 8'h70);
    md(3'b001);
    $display("done: debug");
    rc("status", 4'h5, 8'h07);
    wr(4'h6, 8'h06);
    far.fire(0);
    far.fire(1);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("irq", irq, 1'b1);
    rc("status", 4'h5, 8'h06);
    chk("irq clear", irq, 1'b0);
    wr(4'h4, 8'h00);
    dbg(8'h77, 3'b000, 3'b000);
    chk("active", active, 1'b0);
    far.fire(1);
    rc("count held", 4'h0, 8'h01);
    $display("done: irq and disable");
    finish_test();
  end

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
